// file: src/rtcpc_pkg.sv
/*
 * Constants, register map and state type of the real-time clock prescaler
 * and counter block.
 * Assumes a 32-bit AHB-Lite register bus and a 100 MHz system clock.
 */
package rtcpc_pkg;

  // ****************************************************************
  // register map (byte addresses, low eight address bits)
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_RELOAD_HI = 8'h08;
  localparam logic [7:0] OFS_RELOAD_LO = 8'h0c;
  localparam logic [7:0] OFS_REMAIN_HI = 8'h10;
  localparam logic [7:0] OFS_REMAIN_LO = 8'h14;
  localparam logic [7:0] OFS_COUNT_HI = 8'h18;
  localparam logic [7:0] OFS_COUNT_LO = 8'h1c;

  // ****************************************************************
  // field positions and widths
  // ****************************************************************
  localparam int RELOAD_W = 20;
  localparam int COUNT_W = 32;
  localparam int HALF_W = 16;
  localparam int BIT_TICK_FLAG = 0;
  localparam int BIT_WRAP_FLAG = 2;
  localparam int BIT_CONFIG_MODE = 4;
  localparam int BIT_WRITE_IDLE = 5;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic [19:0] RST_RELOAD = 20'h08000;
  localparam logic [31:0] RST_COUNT = 32'h0000_0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // ****************************************************************
  // bus constants
  // ****************************************************************
  localparam logic HRESP_OKAY = 1'b0;
  localparam int HTRANS_ACTIVE_BIT = 1; // set for NONSEQ and SEQ

  // ****************************************************************
  // write sequencing states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_CONFIG = 3'b010,
    ST_APPLY = 3'b100
  } rtcpc_state_t;

endpackage : rtcpc_pkg

// file: src/rtcpc_top.sv
/*
 * Prescaler and 32-bit tick counter of the real-time clock, with an
 * AHB-Lite register slave.
 * Assumes the source clock arrives as a slow pin level (well below half
 * of CLK_I) and the backup write unlock comes from logic on CLK_I.
 */
`timescale 1ns/1ps
module rtcpc_top (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic RTC_SOURCE_CLOCK_I,
  input wire logic BACKUP_WRITE_UNLOCK_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic [31:0] HRDATA_O
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic src_meta_r, src_sync_r, src_prev_r, src_rise;
  logic dph_valid_r, dph_write_r;
  logic [7:0] dph_addr_r;
  logic addr_ok, wr_any, wr_ctrl, wr_stage;
  rtcpc_pkg::rtcpc_state_t state_r;
  rtcpc_pkg::rtcpc_state_t state_nxt;
  logic [3:0] mark_r; // staged: reload hi, reload lo, count hi, count lo
  logic [3:0] stg_reload_hi_r;
  logic [15:0] stg_reload_lo_r;
  logic [15:0] stg_count_hi_r;
  logic [15:0] stg_count_lo_r;
  logic [19:0] reload_r;
  logic [19:0] reload_nxt;
  logic [19:0] remain_r;
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic apply, tick, wrap;
  logic tick_flag_r, wrap_flag_r, write_idle, config_mode;
  logic [31:0] rd_data;

  // ****************************************************************
  // source clock synchroniser and edge detect
  // ****************************************************************
  // first stage feeds only the second; the edge looks at later stages
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      src_meta_r <= 1'b0;
      src_sync_r <= 1'b0;
      src_prev_r <= 1'b0;
    end else begin
      src_meta_r <= RTC_SOURCE_CLOCK_I;
      src_sync_r <= src_meta_r;
      src_prev_r <= src_sync_r;
    end
  end

  assign src_rise = src_sync_r & ~src_prev_r;

  // ****************************************************************
  // bus address phase capture
  // ****************************************************************
  // only whole-word singles are expected; hsize is not checked
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      dph_valid_r <= 1'b0;
      dph_write_r <= 1'b0;
      dph_addr_r <= 8'h00;
    end else if (HREADY_I) begin
      dph_valid_r <= HSEL_I & HTRANS_I[rtcpc_pkg::HTRANS_ACTIVE_BIT];
      dph_write_r <= HWRITE_I;
      dph_addr_r <= HADDR_I[rtcpc_pkg::ADDR_W-1:0];
    end
  end

  // zero wait states, always okay; same value in and out of reset
  always_ff @(posedge CLK_I) begin
    HREADYOUT_O <= 1'b1;
    HRESP_O <= rtcpc_pkg::HRESP_OKAY;
  end

  // ****************************************************************
  // write qualification
  // ****************************************************************
  assign write_idle = (state_r != rtcpc_pkg::ST_APPLY);
  assign config_mode = (state_r == rtcpc_pkg::ST_CONFIG);
  assign addr_ok = (dph_addr_r[1:0] == 2'b00);
  // unlock and idle gate every write; blocked writes vanish silently
  assign wr_any = dph_valid_r & dph_write_r & addr_ok
                  & BACKUP_WRITE_UNLOCK_I
                  & write_idle;
  assign wr_ctrl = wr_any & (dph_addr_r == rtcpc_pkg::OFS_CONTROL);
  // reload and counter only in configuration mode
  assign wr_stage = wr_any & config_mode;

  // ****************************************************************
  // write sequencing state machine
  // ****************************************************************
  // leaving configuration with staged data waits for a source edge
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rtcpc_pkg::ST_RUN: begin
        if (wr_ctrl && HWDATA_I[rtcpc_pkg::BIT_CONFIG_MODE]) begin
          state_nxt = rtcpc_pkg::ST_CONFIG;
        end
      end
      rtcpc_pkg::ST_CONFIG: begin
        if (wr_ctrl && !HWDATA_I[rtcpc_pkg::BIT_CONFIG_MODE]) begin
          if (mark_r != 4'h0) begin
            state_nxt = rtcpc_pkg::ST_APPLY;
          end else begin
            state_nxt = rtcpc_pkg::ST_RUN;
          end
        end
      end
      rtcpc_pkg::ST_APPLY: begin
        if (src_rise) begin
          state_nxt = rtcpc_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt = rtcpc_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_r <= rtcpc_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // staged values land on a source edge, in step with the prescaler
  assign apply = (state_r == rtcpc_pkg::ST_APPLY) & src_rise;

  // ****************************************************************
  // staging registers
  // ****************************************************************
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      mark_r <= 4'h0;
      stg_reload_hi_r <= 4'h0;
      stg_reload_lo_r <= 16'h0000;
      stg_count_hi_r <= 16'h0000;
      stg_count_lo_r <= 16'h0000;
    end else if (apply) begin
      mark_r <= 4'h0;
    end else if (wr_stage) begin
      case (dph_addr_r)
        rtcpc_pkg::OFS_RELOAD_HI: begin
          stg_reload_hi_r <= HWDATA_I[3:0];
          mark_r[3] <= 1'b1;
        end
        rtcpc_pkg::OFS_RELOAD_LO: begin
          stg_reload_lo_r <= HWDATA_I[15:0];
          mark_r[2] <= 1'b1;
        end
        rtcpc_pkg::OFS_COUNT_HI: begin
          stg_count_hi_r <= HWDATA_I[15:0];
          mark_r[1] <= 1'b1;
        end
        rtcpc_pkg::OFS_COUNT_LO: begin
          stg_count_lo_r <= HWDATA_I[15:0];
          mark_r[0] <= 1'b1;
        end
        default: begin
          mark_r <= mark_r;
        end
      endcase
    end
  end

  // ****************************************************************
  // reload value
  // ****************************************************************
  // marked halves replace the live ones; others are kept
  always_comb begin
    reload_nxt = reload_r;
    if (mark_r[3]) begin
      reload_nxt[19:16] = stg_reload_hi_r;
    end
    if (mark_r[2]) begin
      reload_nxt[15:0] = stg_reload_lo_r;
    end
  end

  // write-only: never returned on the bus
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      reload_r <= rtcpc_pkg::RST_RELOAD;
    end else if (apply) begin
      reload_r <= reload_nxt;
    end
  end

  // ****************************************************************
  // prescaler
  // ****************************************************************
  // divide by reload plus one: count n..0 then reload
  // a reload of zero ticks on every source edge, which the flags
  // cannot be trusted to follow
  assign tick = src_rise & ~apply & (remain_r == 20'h00000);

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      remain_r <= rtcpc_pkg::RST_RELOAD;
    end else if (apply) begin
      remain_r <= reload_nxt;
    end else if (tick) begin
      remain_r <= reload_r;
    end else if (src_rise) begin
      remain_r <= remain_r - 20'h00001;
    end
  end

  // ****************************************************************
  // tick counter
  // ****************************************************************
  always_comb begin
    count_nxt = count_r;
    if (mark_r[1]) begin
      count_nxt[31:16] = stg_count_hi_r;
    end
    if (mark_r[0]) begin
      count_nxt[15:0] = stg_count_lo_r;
    end
  end

  assign wrap = tick & (count_r == 32'hffff_ffff);

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      count_r <= rtcpc_pkg::RST_COUNT;
    end else if (apply) begin
      count_r <= count_nxt;
    end else if (tick) begin
      count_r <= count_r + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // event flags
  // ****************************************************************
  // software clears by writing zero; a same-cycle event wins
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      tick_flag_r <= 1'b0;
      wrap_flag_r <= 1'b0;
    end else begin
      if (tick) begin
        tick_flag_r <= 1'b1;
      end else if (wr_ctrl && !HWDATA_I[rtcpc_pkg::BIT_TICK_FLAG]) begin
        tick_flag_r <= 1'b0;
      end
      if (wrap) begin
        wrap_flag_r <= 1'b1;
      end else if (wr_ctrl && !HWDATA_I[rtcpc_pkg::BIT_WRAP_FLAG]) begin
        wrap_flag_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // decoded in the address phase so data stands with zero waits
  always_comb begin
    rd_data = rtcpc_pkg::RST_RDATA;
    case (HADDR_I[rtcpc_pkg::ADDR_W-1:0])
      rtcpc_pkg::OFS_CONTROL: begin
        rd_data[rtcpc_pkg::BIT_TICK_FLAG] = tick_flag_r;
        rd_data[rtcpc_pkg::BIT_WRAP_FLAG] = wrap_flag_r;
        rd_data[rtcpc_pkg::BIT_CONFIG_MODE] = config_mode;
        rd_data[rtcpc_pkg::BIT_WRITE_IDLE] = write_idle;
      end
      rtcpc_pkg::OFS_REMAIN_HI: begin
        rd_data[3:0] = remain_r[19:16];
      end
      rtcpc_pkg::OFS_REMAIN_LO: begin
        rd_data[15:0] = remain_r[15:0];
      end
      rtcpc_pkg::OFS_COUNT_HI: begin
        rd_data[15:0] = count_r[31:16];
      end
      rtcpc_pkg::OFS_COUNT_LO: begin
        rd_data[15:0] = count_r[15:0];
      end
      default: begin
        rd_data = rtcpc_pkg::RST_RDATA;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      HRDATA_O <= rtcpc_pkg::RST_RDATA;
    end else if (HREADY_I && HSEL_I && !HWRITE_I
                 && HTRANS_I[rtcpc_pkg::HTRANS_ACTIVE_BIT]) begin
      HRDATA_O <= rd_data;
    end else begin
      HRDATA_O <= rtcpc_pkg::RST_RDATA;
    end
  end

endmodule : rtcpc_top

// file: verif/rtcpc_monitor.sv
/* port checker of the rtc prescaler and counter block.
   assumes a bind onto rtcpc_top and one clock domain. */
`timescale 1ns/1ps
module rtcpc_monitor (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic HREADY_I,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic [31:0] HRDATA_O
);
  // ****************************************************************
  // helper logic
  // ****************************************************************
  logic rd_r;
  logic [7:0] ad_r;
  // marks the data phase of each taken read
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rd_r <= 1'b0;
      ad_r <= 8'h00;
    end else begin
      rd_r <= HSEL_I & HTRANS_I[1] & HREADY_I & ~HWRITE_I;
      ad_r <= HADDR_I[7:0];
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // ****************************************************************
  // assertions
  // ****************************************************************
  chk_ready_held: assert property (HREADYOUT_O [*8])
    else $error("hready dropped");
  chk_resp_okay: assert property (!HRESP_O) else $error("resp not okay");
  chk_idle_data: assert property (!rd_r |-> HRDATA_O == 32'h0)
    else $error("read data outside data phase");
  chk_reload_wo: assert property (
    rd_r && (ad_r == 8'h08 || ad_r == 8'h0c) |-> HRDATA_O == 32'h0)
    else $error("reload register readable");
  chk_unmapped_zero: assert property (
    rd_r && (ad_r == 8'h00 || ad_r > 8'h1c) |-> HRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  chk_remain_high: assert property (
    rd_r && ad_r == 8'h10 |-> HRDATA_O[31:4] == 28'h0)
    else $error("remainder high too wide");
  chk_half_width: assert property (
    rd_r && ad_r inside {8'h14, 8'h18, 8'h1c} |-> HRDATA_O[31:16] == 16'h0)
    else $error("half register too wide");
  chk_ctrl_bits: assert property (
    rd_r && ad_r == 8'h04 |-> (HRDATA_O & ~32'h35) == 32'h0)
    else $error("control reserved bits set");
  // main scenarios
  cover property (rd_r && ad_r == 8'h18 && HRDATA_O != 32'h0);
  cover property (rd_r && ad_r == 8'h04 && HRDATA_O[2]);
  cover property (rd_r && ad_r == 8'h04 && !HRDATA_O[5]);
endmodule : rtcpc_monitor

bind rtcpc_top rtcpc_monitor rtcpc_monitor_i (.CLK_I, .RESET_I, .HSEL_I,
  .HADDR_I, .HTRANS_I, .HWRITE_I, .HREADY_I, .HREADYOUT_O, .HRESP_O,
  .HRDATA_O);

// file: verif/tb_rtcpc_top.sv
/* self-checking bench of rtcpc_top over ahb-lite.
   assumes zero wait states are not relied on; source clock is slow. */
`timescale 1ns/1ps
module tb_rtcpc_top;
  logic clk = 1'b0, rst = 1'b1, src = 1'b0, unl = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'b00;
  logic hrdy, hresp;
  int errors = 0, checked = 0;
  // 100 mhz clock
  always #5 clk = ~clk;
  rtcpc_top rtcpc_top_i (.CLK_I(clk), .RESET_I(rst),
    .RTC_SOURCE_CLOCK_I(src), .BACKUP_WRITE_UNLOCK_I(unl), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hrdy),
    .HREADYOUT_O(hrdy), .HRESP_O(hresp), .HRDATA_O(hrdata));
  // ****************************************************************
  // bus and pin tasks
  // ****************************************************************
  // values read just after an edge are the pre-edge ones
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    // no wait count assumed; only the watchdog ends a stuck wait
    while (hrdy !== 1'b1) begin
      @(posedge clk);
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) begin
      @(posedge clk);
    end
    q = hrdata;
    @(posedge clk); // idle cycle so a following read sees new data
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    checked++;
    if (q !== e) begin
      errors++;
      $display("wrong value reg %h expected %h seen %h", a, e, q);
    end
  endtask : rd
  // levels held four cycles, above the three-cycle sync latency
  task automatic edges(input int n);
    repeat (n) begin
      src <= 1'b1;
      repeat (4) @(posedge clk);
      src <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : edges
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h8000);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h04, 32'h20);
    rd(8'h30, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_lock;
    unl <= 1'b0;
    wr(8'h04, 32'h15);
    wr(8'h18, 32'h1111);
    wr(8'h04, 32'h05);
    rd(8'h04, 32'h20);
    rd(8'h18, 32'h0);
    unl <= 1'b1;
    wr(8'h18, 32'h2222);
    rd(8'h18, 32'h0);
    wr(8'h04, 32'h15);
    wr(8'h04, 32'h05);
    rd(8'h04, 32'h20);
    $display("test lock done");
  endtask : t_lock
  task automatic t_cfg;
    wr(8'h04, 32'h15);
    rd(8'h04, 32'h30);
    wr(8'h0c, 32'h3);
    wr(8'h18, 32'habcd);
    wr(8'h1c, 32'hfffe);
    rd(8'h18, 32'h0);
    wr(8'h04, 32'h05);
    rd(8'h04, 32'h00);
    wr(8'h04, 32'h15);
    edges(1);
    rd(8'h04, 32'h20);
    rd(8'h18, 32'habcd);
    rd(8'h1c, 32'hfffe);
    rd(8'h14, 32'h3);
    $display("test config done");
  endtask : t_cfg
  task automatic t_count;
    edges(1);
    rd(8'h14, 32'h2);
    edges(3);
    rd(8'h14, 32'h3);
    rd(8'h1c, 32'hffff);
    rd(8'h04, 32'h21);
    edges(4);
    rd(8'h18, 32'habce);
    rd(8'h1c, 32'h0);
    wr(8'h04, 32'h04);
    rd(8'h04, 32'h20);
    $display("test count done");
  endtask : t_count
  task automatic t_wrap;
    wr(8'h04, 32'h15);
    wr(8'h18, 32'hffff);
    wr(8'h1c, 32'hffff);
    wr(8'h04, 32'h05);
    edges(5);
    rd(8'h18, 32'h0);
    rd(8'h04, 32'h25);
    wr(8'h04, 32'h01);
    rd(8'h04, 32'h21);
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_high;
    wr(8'h04, 32'h15);
    wr(8'h08, 32'h1);
    wr(8'h0c, 32'h2);
    wr(8'h04, 32'h05);
    wr(8'h04, 32'h10);
    edges(1);
    rd(8'h04, 32'h21);
    rd(8'h10, 32'h1);
    rd(8'h14, 32'h2);
    wr(8'h14, 32'h7);
    rd(8'h14, 32'h2);
    edges(1);
    rd(8'h14, 32'h1);
    $display("test high done");
  endtask : t_high
  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_lock;
    t_cfg;
    t_count;
    t_wrap;
    t_high;
    final_report;
  end
  // watchdog, well above the few hundred cycles needed
  initial begin
    #200us;
    errors++;
    final_report;
  end
endmodule : tb_rtcpc_top
